/* gpio_params.svh */
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH

// ----------------------------------------------------------------
// pin counts and port widths
// ----------------------------------------------------------------
`define GPIO_NPINS 38
`define GPIO_NPORTS 7
`define GPIO_W_PORT_A 4
`define GPIO_W_PORT_B 4
`define GPIO_W_PORT_C 6
`define GPIO_W_PORT_D 4
`define GPIO_W_PORT_E 8
`define GPIO_W_PORT_F 5
`define GPIO_W_PORT_G 7

// ----------------------------------------------------------------
// register map, byte addresses
// ----------------------------------------------------------------
`define GPIO_ADDR_W 12
`define GPIO_PAGE0_BASE 12'h000
`define GPIO_PAGE0_STRIDE 12'h008
`define GPIO_OFS_VALUE 12'h000
`define GPIO_OFS_DIR 12'h004
`define GPIO_HIGH_BASE 12'h100
`define GPIO_HIGH_STRIDE 12'h010
`define GPIO_OFS_PULL 12'h000
`define GPIO_OFS_SLEW 12'h004
`define GPIO_OFS_DRIVE 12'h008

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define GPIO_VALUE_RST 38'h00_0000_0000
`define GPIO_DIR_RST 38'h00_0000_0000
`define GPIO_PULL_RST 38'h00_0000_0000
`define GPIO_SLEW_RST 38'h3F_FFFF_FFFF
`define GPIO_DRIVE_RST 38'h00_0000_0000

// ----------------------------------------------------------------
// keypad pins carrying both pull devices (flat pin index)
// ----------------------------------------------------------------
`define GPIO_NKEYPAD_PULL 3
`define GPIO_KEYPAD_PULL_PIN0 16
`define GPIO_KEYPAD_PULL_PIN1 17
`define GPIO_KEYPAD_PULL_PIN2 35

`endif

/* gpio_pkg.sv */
`include "gpio_params.svh"

package gpio_pkg;

    // register kinds within a port
    typedef enum logic [2:0] {
        K_VALUE,
        K_DIR,
        K_PULL,
        K_SLEW,
        K_DRIVE
    } reg_kind_e;

    // decoded bus address
    typedef struct packed {
        logic hit;
        logic [2:0] port;
        reg_kind_e kind;
    } reg_sel_s;

    // request from the on-chip peripherals, one bit per pin
    typedef struct packed {
        logic [`GPIO_NPINS-1:0] en;
        logic [`GPIO_NPINS-1:0] oe;
        logic [`GPIO_NPINS-1:0] out;
        logic [`GPIO_NPINS-1:0] analog;
    } periph_req_s;

    // drive towards the pad ring, one bit per pin
    typedef struct packed {
        logic [`GPIO_NPINS-1:0] out;
        logic [`GPIO_NPINS-1:0] oe;
        logic [`GPIO_NPINS-1:0] pull_up;
        logic [`GPIO_NPINS-1:0] pull_down;
        logic [`GPIO_NPINS-1:0] slew;
        logic [`GPIO_NPINS-1:0] high_drive;
    } pad_drive_s;

endpackage

/* gpio_pin_cell.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// per-pin ownership and drive mux
// ----------------------------------------------------------------
module gpio_pin_cell #(
    parameter int W = 38
) (
    // register state
    input wire logic [W-1:0] value_q,
    input wire logic [W-1:0] dir_q,
    input wire logic [W-1:0] pull_q,
    input wire logic [W-1:0] slew_q,
    input wire logic [W-1:0] drive_q,
    // peripheral request
    input wire logic [W-1:0] p_en,
    input wire logic [W-1:0] p_oe,
    input wire logic [W-1:0] p_out,
    input wire logic [W-1:0] p_analog,
    // pad side
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pad_out,
    output logic [W-1:0] pad_oe,
    output logic [W-1:0] pull_allow,
    output logic [W-1:0] pad_slew,
    output logic [W-1:0] pad_high_drive,
    // toward peripherals and bus readback
    output logic [W-1:0] level,
    output logic [W-1:0] readback
);

    logic [W-1:0] digital_own; // digital peripheral owns pin, analog absent

    // analog beats every digital claim
    assign digital_own = p_en & ~p_analog; // [R07]

    // direction: peripheral overrides, else parallel io, analog kills driver
    assign pad_oe = ~p_analog & ((digital_own & p_oe) | (~digital_own & dir_q)); // [R04] [R06] [R08]

    // output data: peripheral value on its pins, else stored value
    assign pad_out = (digital_own & p_out) | (~digital_own & value_q); // [R05] [R08]

    // pullup only on digital inputs
    assign pull_allow = pull_q & ~pad_oe & ~p_analog; // [R16]

    // slew and drive pass through, they matter only on outputs
    assign pad_slew = slew_q;
    assign pad_high_drive = drive_q;

    // digital input path blanked on analog pins
    assign level = pin_in & ~p_analog; // [R06]

    // readback: direction bit picks pin or latch, analog reads zero
    assign readback = ~p_analog & ((dir_q & value_q) | (~dir_q & pin_in)); // [R14] [R15]

endmodule

`default_nettype wire

/* gpio_ports.sv */
`timescale 1ns/1ps
`default_nettype none
`include "gpio_params.svh"

// Functional notes
// R01: reset hands every pin to parallel io
// R02: reset makes every pin an input
// R03: reset: slew on, low drive, pullup off
// R04: enabled peripheral sets the pin direction
// R05: peripheral output pins drive peripheral data
// R06: analog pins lose all digital function
// R07: analog wins over digital peripheral claims
// R08: unclaimed pins fall back to parallel io
// R09: 38 pins, each with own control bits
// R10: port widths 4,4,6,4,8,5,7 bits
// R11: value/direction low page, controls high page
// R12: keypad pins pull down on rising edge
// R13: interrupt pin pull follows enable and edge
// R14: value read: pin if input, latch if output
// R15: analog pins read back as zero
// R16: pullup off for outputs and analog pins
// R17: value writes stored even on inputs

module gpio_ports
    import gpio_pkg::*;
(
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [`GPIO_ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // on-chip peripherals
    input wire gpio_pkg::periph_req_s PERIPH_REQ,
    input wire logic [`GPIO_NKEYPAD_PULL-1:0] KEYPAD_PIN_ENABLE,
    input wire logic [`GPIO_NKEYPAD_PULL-1:0] KEYPAD_EDGE_POLARITY,
    input wire logic EXT_INTERRUPT_PIN_ENABLE,
    input wire logic EXT_INTERRUPT_EDGE_SELECT,
    output logic [`GPIO_NPINS-1:0] PIN_LEVEL,
    // pads
    input wire logic [`GPIO_NPINS-1:0] PIN_IN,
    output gpio_pkg::pad_drive_s PAD,
    output logic IRQ_PULLUP_EN,
    output logic IRQ_PULLDOWN_EN
);

    import gpio_pkg::*;

    // ----------------------------------------------------------------
    // geometry helpers
    // ----------------------------------------------------------------

    localparam int NP = `GPIO_NPINS;

    // width of each port
    function automatic int port_width(input logic [2:0] p);
        int w;
        w = 0;
        unique case (p)
            3'h0: w = `GPIO_W_PORT_A; // [R10]
            3'h1: w = `GPIO_W_PORT_B;
            3'h2: w = `GPIO_W_PORT_C;
            3'h3: w = `GPIO_W_PORT_D;
            3'h4: w = `GPIO_W_PORT_E;
            3'h5: w = `GPIO_W_PORT_F;
            3'h6: w = `GPIO_W_PORT_G;
            default: w = 0;
        endcase
        return w;
    endfunction

    // first flat pin index of a port
    function automatic int port_base(input logic [2:0] p);
        int b;
        b = 0;
        for (int q = 0; q < `GPIO_NPORTS; q++) begin
            if (3'(q) < p) begin
                b += port_width(3'(q));
            end
        end
        return b;
    endfunction

    // port holding a flat pin
    function automatic logic [2:0] pin_port(input int i);
        int b;
        logic [2:0] r;
        b = 0;
        r = 3'h0;
        for (int q = 0; q < `GPIO_NPORTS; q++) begin
            if (i >= b) begin
                r = 3'(q);
            end
            b += port_width(3'(q));
        end
        return r;
    endfunction

    // bit position of a flat pin within its port
    function automatic logic [2:0] pin_bit(input int i);
        return 3'(i - port_base(pin_port(i)));
    endfunction

    // gather one port's bits from a flat vector, empty positions zero
    function automatic logic [7:0] port_field(input logic [NP-1:0] v, input logic [2:0] p);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < NP; i++) begin
            if (pin_port(i) == p) begin
                r[pin_bit(i)] = v[i]; // [R09] [R10]
            end
        end
        return r;
    endfunction

    // scatter a write into one port of a flat vector
    function automatic logic [NP-1:0] port_merge(input logic [NP-1:0] v, input logic [2:0] p,
                                                 input logic [7:0] w);
        logic [NP-1:0] r;
        r = v;
        for (int i = 0; i < NP; i++) begin
            if (pin_port(i) == p) begin
                r[i] = w[pin_bit(i)];
            end
        end
        return r;
    endfunction

    // address decode: low page and high page
    function automatic reg_sel_s decode(input logic [`GPIO_ADDR_W-1:0] a);
        reg_sel_s s;
        logic [`GPIO_ADDR_W-1:0] rel;
        s.hit = 1'b0;
        s.port = 3'h0;
        s.kind = K_VALUE;
        rel = a - `GPIO_HIGH_BASE;
        if (a[1:0] == 2'h0 && a < `GPIO_PAGE0_BASE + 12'(`GPIO_NPORTS) * `GPIO_PAGE0_STRIDE) begin
            // low page: value and direction
            s.hit = 1'b1; // [R11]
            s.port = 3'((a - `GPIO_PAGE0_BASE) / `GPIO_PAGE0_STRIDE);
            s.kind = (a[2:0] == `GPIO_OFS_DIR) ? K_DIR : K_VALUE;
        end else if (a[1:0] == 2'h0 && a >= `GPIO_HIGH_BASE &&
                     rel < 12'(`GPIO_NPORTS) * `GPIO_HIGH_STRIDE && rel[3:0] <= `GPIO_OFS_DRIVE) begin
            // high page: pin controls
            s.hit = 1'b1; // [R11]
            s.port = 3'(rel / `GPIO_HIGH_STRIDE);
            unique case (rel[3:0])
                `GPIO_OFS_PULL: s.kind = K_PULL;
                `GPIO_OFS_SLEW: s.kind = K_SLEW;
                default: s.kind = K_DRIVE;
            endcase
        end
        return s;
    endfunction

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------

    reg_sel_s sel; // decoded current address
    logic wr_en; // write takes effect this edge
    logic setup; // setup phase of any transfer

    assign sel = decode(PADDR);
    assign setup = PSEL & ~PENABLE;
    assign wr_en = PSEL & PENABLE & PWRITE & sel.hit;

    // zero wait states
    assign PREADY = PSEL & PENABLE;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------

    logic [NP-1:0] value_q; // port value latch
    logic [NP-1:0] dir_q; // pin direction bits
    logic [NP-1:0] pull_q; // pullup enable bits
    logic [NP-1:0] slew_q; // slew limit bits
    logic [NP-1:0] drive_q; // high drive bits
    periph_req_s periph_q; // registered peripheral request

    // value latch, written regardless of direction
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            value_q <= `GPIO_VALUE_RST;
        end else if (wr_en && sel.kind == K_VALUE) begin
            value_q <= port_merge(value_q, sel.port, PWDATA[7:0]); // [R17]
        end
    end

    // direction bits, all inputs after reset
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            dir_q <= `GPIO_DIR_RST; // [R02]
        end else if (wr_en && sel.kind == K_DIR) begin
            dir_q <= port_merge(dir_q, sel.port, PWDATA[7:0]);
        end
    end

    // pin control bits in the high page
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            pull_q <= `GPIO_PULL_RST; // [R03]
            slew_q <= `GPIO_SLEW_RST; // [R03]
            drive_q <= `GPIO_DRIVE_RST; // [R03]
        end else if (wr_en) begin
            // one control group per write
            if (sel.kind == K_PULL) begin
                pull_q <= port_merge(pull_q, sel.port, PWDATA[7:0]);
            end
            if (sel.kind == K_SLEW) begin
                slew_q <= port_merge(slew_q, sel.port, PWDATA[7:0]);
            end
            if (sel.kind == K_DRIVE) begin
                drive_q <= port_merge(drive_q, sel.port, PWDATA[7:0]);
            end
        end
    end

    // peripheral claims held off through reset
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            periph_q <= '0; // [R01]
        end else begin
            periph_q <= PERIPH_REQ;
        end
    end

    // ----------------------------------------------------------------
    // pin logic
    // ----------------------------------------------------------------

    logic [NP-1:0] pull_allow; // pullup permitted before keypad steering
    logic [NP-1:0] readback; // value register read image
    logic [NP-1:0] keypad_down; // keypad pins switched to pulldown

    gpio_pin_cell #(
        .W(NP)
    ) u_cell (
        .value_q(value_q),
        .dir_q(dir_q),
        .pull_q(pull_q),
        .slew_q(slew_q),
        .drive_q(drive_q),
        .p_en(periph_q.en),
        .p_oe(periph_q.oe),
        .p_out(periph_q.out),
        .p_analog(periph_q.analog),
        .pin_in(PIN_IN),
        .pad_out(PAD.out),
        .pad_oe(PAD.oe),
        .pull_allow(pull_allow),
        .pad_slew(PAD.slew),
        .pad_high_drive(PAD.high_drive),
        .level(PIN_LEVEL),
        .readback(readback)
    );

    // keypad pins flip to pulldown on rising-edge polarity
    always_comb begin
        keypad_down = '0;
        keypad_down[`GPIO_KEYPAD_PULL_PIN0] = KEYPAD_PIN_ENABLE[0] & KEYPAD_EDGE_POLARITY[0]; // [R12]
        keypad_down[`GPIO_KEYPAD_PULL_PIN1] = KEYPAD_PIN_ENABLE[1] & KEYPAD_EDGE_POLARITY[1]; // [R12]
        keypad_down[`GPIO_KEYPAD_PULL_PIN2] = KEYPAD_PIN_ENABLE[2] & KEYPAD_EDGE_POLARITY[2]; // [R12]
    end

    // pull device steering
    assign PAD.pull_up = pull_allow & ~keypad_down; // [R12] [R16]
    assign PAD.pull_down = pull_allow & keypad_down; // [R12]

    // interrupt pin pull, off unless the pin is enabled
    assign IRQ_PULLUP_EN = EXT_INTERRUPT_PIN_ENABLE & ~EXT_INTERRUPT_EDGE_SELECT; // [R13]
    assign IRQ_PULLDOWN_EN = EXT_INTERRUPT_PIN_ENABLE & EXT_INTERRUPT_EDGE_SELECT; // [R13]

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------

    logic [7:0] rd_field; // selected port image

    // select read image by register kind
    always_comb begin
        rd_field = 8'h00;
        unique case (sel.kind)
            K_VALUE: rd_field = port_field(readback, sel.port); // [R14] [R15]
            K_DIR: rd_field = port_field(dir_q, sel.port);
            K_PULL: rd_field = port_field(pull_q, sel.port);
            K_SLEW: rd_field = port_field(slew_q, sel.port);
            K_DRIVE: rd_field = port_field(drive_q, sel.port);
            default: rd_field = 8'h00;
        endcase
    end

    // read data and error captured in the setup phase
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else if (setup) begin
            PRDATA <= {24'h00_0000, sel.hit ? rd_field : 8'h00};
            PSLVERR <= ~sel.hit;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------

    // direction cleared right after reset
    chk_reset_dir: assert property (@(posedge SYS_CLK) $past(RST) && !RST |-> dir_q == '0) // [R02]
        else $error("direction not cleared by reset");

    // pin controls take reset values
    chk_reset_ctrl: assert property (@(posedge SYS_CLK) $past(RST) && !RST |->
        slew_q == `GPIO_SLEW_RST && drive_q == '0 && pull_q == '0) // [R03]
        else $error("pin control reset values wrong");

    // no peripheral owns a pin right after reset
    chk_reset_owner: assert property (@(posedge SYS_CLK) $past(RST) && !RST |->
        PAD.oe == dir_q && PAD.out == value_q) // [R01]
        else $error("peripheral owns pin after reset");

    // peripheral request reaches the pad one cycle later
    chk_periph_dir: assert property (@(posedge SYS_CLK) disable iff (RST)
        $past(!RST) |-> ((PAD.oe ^ $past(PERIPH_REQ.oe)) & $past(PERIPH_REQ.en) & ~$past(PERIPH_REQ.analog)) == '0) // [R04]
        else $error("peripheral direction not applied");

    // peripheral output data on owned output pins
    chk_periph_data: assert property (@(posedge SYS_CLK) disable iff (RST)
        ((PAD.out ^ periph_q.out) & periph_q.en & ~periph_q.analog & PAD.oe) == '0) // [R05]
        else $error("peripheral data not driven");

    // analog pins have no driver, no pull, no level
    chk_analog_off: assert property (@(posedge SYS_CLK) disable iff (RST)
        ((PAD.oe | PAD.pull_up | PAD.pull_down | PIN_LEVEL) & periph_q.analog) == '0) // [R06] [R07]
        else $error("digital function on analog pin");

    // unclaimed pins follow direction and value latch
    chk_gpio_fallback: assert property (@(posedge SYS_CLK) disable iff (RST)
        (((PAD.oe ^ dir_q) | (PAD.out ^ value_q)) & ~periph_q.en & ~periph_q.analog) == '0) // [R08]
        else $error("unclaimed pin not under parallel io");

    // pullup never on an output
    chk_pullup_off: assert property (@(posedge SYS_CLK) disable iff (RST)
        ((PAD.pull_up | PAD.pull_down) & PAD.oe) == '0) // [R16]
        else $error("pull device on output pin");

    // third keypad pin: pulldown only with enable and rising polarity
    chk_keypad_pull: assert property (@(posedge SYS_CLK) disable iff (RST)
        PAD.pull_down[`GPIO_KEYPAD_PULL_PIN2] |-> KEYPAD_PIN_ENABLE[2] && KEYPAD_EDGE_POLARITY[2]) // [R12]
        else $error("keypad pulldown without cause");

    // first keypad pin: pulldown only with enable and rising polarity
    chk_keypad_first: assert property (@(posedge SYS_CLK) disable iff (RST)
        PAD.pull_down[`GPIO_KEYPAD_PULL_PIN0] |-> KEYPAD_PIN_ENABLE[0] && KEYPAD_EDGE_POLARITY[0]) // [R12]
        else $error("first keypad pulldown without cause");

    // interrupt pin pull follows enable and edge
    chk_irq_pull: assert property (@(posedge SYS_CLK) disable iff (RST)
        (IRQ_PULLUP_EN | IRQ_PULLDOWN_EN) == EXT_INTERRUPT_PIN_ENABLE &&
        IRQ_PULLDOWN_EN == (EXT_INTERRUPT_PIN_ENABLE && EXT_INTERRUPT_EDGE_SELECT)) // [R13]
        else $error("interrupt pin pull wrong");

    // value write is stored whatever the direction
    chk_value_store: assert property (@(posedge SYS_CLK) disable iff (RST)
        wr_en && sel.kind == K_VALUE |=> port_field(value_q, $past(sel.port)) ==
        ($past(PWDATA[7:0]) & port_field('1, $past(sel.port)))) // [R17]
        else $error("value write lost");

    // value read returns pin, latch or zero as selected
    chk_value_read: assert property (@(posedge SYS_CLK) disable iff (RST)
        setup && !PWRITE && sel.hit && sel.kind == K_VALUE |=>
        PRDATA[7:0] == port_field(~$past(periph_q.analog) & (($past(dir_q) & $past(value_q)) |
        (~$past(dir_q) & $past(PIN_IN))), $past(sel.port))) // [R14] [R15]
        else $error("value readback wrong");

    // unmapped access answers with an error
    chk_unmapped_err: assert property (@(posedge SYS_CLK) disable iff (RST)
        setup && !sel.hit |=> PSLVERR && PRDATA == 32'h0000_0000)
        else $error("unmapped access not flagged");

endmodule

`default_nettype wire

/* board_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "gpio_params.svh"

// ----------------------------------------------------------------
// board wiring behind the pads
// ----------------------------------------------------------------
module board_model
    import gpio_pkg::*;
(
    // drive coming out of the block
    input wire gpio_pkg::pad_drive_s pad_drv,
    // level the board puts on undriven pins
    input wire logic [`GPIO_NPINS-1:0] ext_lvl,
    // resolved wire level
    output logic [`GPIO_NPINS-1:0] pin_lvl
);
    // block driver wins, then a lone pull device, then the board
    always_comb begin
        for (int i = 0; i < `GPIO_NPINS; i++) begin
            if (pad_drv.oe[i]) begin
                pin_lvl[i] = pad_drv.out[i];
            end else if (pad_drv.pull_up[i] ^ pad_drv.pull_down[i]) begin
                pin_lvl[i] = pad_drv.pull_up[i];
            end else begin
                pin_lvl[i] = ext_lvl[i];
            end
        end
    end
endmodule
`default_nettype wire

/* test_shared_parallel_io_ports.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; $display("mismatch t=%0t got %h exp %h", $time, g, e); end end

module test_shared_parallel_io_ports;
    import gpio_pkg::*;
    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    typedef struct {logic [11:0] a; logic [7:0] w; logic [7:0] e; logic s;} row_s;
    logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, irq_en = 0, irq_edge = 0, irq_up, irq_dn, er;
    periph_req_s preq = '0;
    logic [2:0] kb_en = '0, kb_pol = '0;
    logic [37:0] ext = '0, pin, lvl;
    pad_drive_s pad;
    logic [7:0] rd;
    int errors = 0, cmp_count = 0;
    // implemented bits of ports a..g
    logic [7:0] mask [7] = '{8'h0F, 8'h0F, 8'h3F, 8'h0F, 8'hFF, 8'h1F, 8'h7F};
    // write, read back; last two hit no register
    row_s rows [9] = '{'{12'h004, 8'hFF, 8'h0F, 1'b0}, '{12'h014, 8'hFF, 8'h3F, 1'b0},
        '{12'h024, 8'hFF, 8'hFF, 1'b0}, '{12'h034, 8'hFF, 8'h7F, 1'b0}, '{12'h158, 8'hFF, 8'h1F, 1'b0},
        '{12'h114, 8'h00, 8'h00, 1'b0}, '{12'h138, 8'hFF, 8'h0F, 1'b0}, '{12'h200, 8'hFF, 8'h00, 1'b1},
        '{12'h002, 8'hFF, 8'h00, 1'b1}};

    always #12.5 sys_clk = ~sys_clk;

    gpio_ports dut_u (.SYS_CLK(sys_clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .PERIPH_REQ(preq), .KEYPAD_PIN_ENABLE(kb_en), .KEYPAD_EDGE_POLARITY(kb_pol),
        .EXT_INTERRUPT_PIN_ENABLE(irq_en), .EXT_INTERRUPT_EDGE_SELECT(irq_edge), .PIN_LEVEL(lvl),
        .PIN_IN(pin), .PAD(pad), .IRQ_PULLUP_EN(irq_up), .IRQ_PULLDOWN_EN(irq_dn));
    board_model brd_u (.pad_drv(pad), .ext_lvl(ext), .pin_lvl(pin));

    // ----------------------------------------------------------------
    // apb transfer: setup, then access until pready
    // ----------------------------------------------------------------
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) errors++;
        rd = prdata[7:0];
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    // peripheral request, given time to pass its register
    task automatic setp(input logic [37:0] en, oe, o, an);
        @(posedge sys_clk);
        preq <= {en, oe, o, an};
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // watchdog far beyond the few hundred cycles needed
    initial begin
        #(25 * 5000);
        errors++;
        print_verdict();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 0;
        foreach (rows[i]) begin
            xfer(1, rows[i].a, rows[i].w);
            xfer(0, rows[i].a, 8'h00);
            `CHK(rd, rows[i].e)
            `CHK(er, rows[i].s)
        end
        $display("register table test done");
        // reset with every peripheral asking for output
        @(posedge sys_clk);
        rst <= 1;
        preq <= {{76{1'b1}}, 76'h0};
        repeat (12) @(posedge sys_clk);
        #1;
        `CHK(pad.oe, 38'h0)
        `CHK(pad.slew, {38{1'b1}})
        `CHK(pad.high_drive | pad.pull_up, 38'h0)
        @(posedge sys_clk);
        preq <= '0;
        rst <= 0;
        for (int p = 0; p < 7; p++) begin
            xfer(0, 12'(p * 8 + 4), 8'h00);
            `CHK(rd, 8'h00)
            xfer(0, 12'(p * 16 + 'h104), 8'h00);
            `CHK(rd, mask[p])
            xfer(0, 12'(p * 16 + 'h100), 8'h00);
            `CHK(rd, 8'h00)
            xfer(0, 12'(p * 16 + 'h108), 8'h00);
            `CHK(rd, 8'h00)
        end
        $display("reset test done");
        // port a: value stored while input, pin read back
        @(posedge sys_clk);
        ext <= 38'hA;
        xfer(1, 12'h000, 8'h07);
        xfer(0, 12'h000, 8'h00);
        `CHK(rd, 8'h0A)
        xfer(1, 12'h004, 8'h0F);
        xfer(1, 12'h100, 8'h0F);
        #1;
        `CHK(pad.oe[3:0], 4'hF)
        `CHK(pad.out[3:0], 4'h7)
        `CHK(pad.pull_up[3:0], 4'h0)
        // pin0 peripheral output 0, pin1 analog and digital, pin2 peripheral input
        setp(38'h7, 38'h1, 38'h0, 38'h2);
        `CHK(pad.oe[3:0], 4'h9)
        `CHK(pad.out[0], 1'b0)
        `CHK(lvl[1], 1'b0)
        `CHK(pad.pull_up[2:1], 2'b10)
        xfer(0, 12'h000, 8'h00);
        `CHK(rd, 8'h05)
        setp('0, '0, '0, '0);
        `CHK({pad.oe[3:0], pad.out[3:0]}, 8'hF7)
        xfer(1, 12'h004, 8'h00);
        #1;
        `CHK(pad.pull_up[3:0], 4'hF)
        $display("ownership test done");
        // keypad pin on port d bit 2, both polarities
        xfer(1, 12'h130, 8'h04);
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk);
            kb_en <= 3'h1;
            kb_pol <= 3'(k);
            @(posedge sys_clk);
            #1;
            `CHK({pad.pull_up[16], pad.pull_down[16]}, (k == 1) ? 2'b01 : 2'b10)
        end
        // interrupt pin pull, all four combinations
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            irq_en <= i[1];
            irq_edge <= i[0];
            @(posedge sys_clk);
            #1;
            `CHK({irq_up, irq_dn}, {i[1] & ~i[0], i[1] & i[0]})
        end
        $display("pull device test done");
        print_verdict();
    end
endmodule
`default_nettype wire
